/* File: inc/pdphp_pkg.sv */
// Shared constants and carrier types of the palette DAC pixel and host port.
// Assumes a single pixel clock; host strobes arrive asynchronously to it.
package pdphp_pkg;

  // Register select codes of the host port
  localparam logic [2:0] SEL_PAL_PTR_WR = 3'h0;
  localparam logic [2:0] SEL_PALETTE = 3'h1;
  localparam logic [2:0] SEL_PIX_MASK = 3'h2;
  localparam logic [2:0] SEL_PAL_PTR_RD = 3'h3;
  localparam logic [2:0] SEL_OVL_PTR_WR = 3'h4;
  localparam logic [2:0] SEL_OVERLAY = 3'h5;
  localparam logic [2:0] SEL_RESERVED = 3'h6;
  localparam logic [2:0] SEL_OVL_PTR_RD = 3'h7;

  // Color cycle counter values, modulo three
  localparam logic [1:0] CYC_RED = 2'h0;
  localparam logic [1:0] CYC_GREEN = 2'h1;
  localparam logic [1:0] CYC_BLUE = 2'h2;

  // Values after reset
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] PIX_MASK_RST = 8'hFF;
  localparam logic [7:0] DATA_RST = 8'h00;

  // Palette and overlay geometry
  localparam int PALETTE_DEPTH = 256;
  localparam int OVL_ENTRIES = 16;
  localparam logic [3:0] OVL_PASS = 4'h0;

  // Fetch delay: pointer update, then registered palette read
  localparam logic [1:0] FETCH_START = 2'h1;

  typedef enum logic [1:0] {
    PDPHP_PAL_WR,
    PDPHP_PAL_RD,
    PDPHP_OVL_WR,
    PDPHP_OVL_RD
  } pdphp_mode_e;

  typedef struct packed {
    logic [7:0] index;
    logic [3:0] overlay;
    logic sync_n;
    logic blank_n;
  } pdphp_pixel_s;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } pdphp_color_s;

endpackage

/* File: verilog/pdphp_sync2.sv */
// Two flip-flop synchroniser for asynchronous pins.
// Assumes each bit is an independent level; first stage feeds only the second.
`timescale 1ns/100ps
`default_nettype none

module pdphp_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  // Width check
  if (WIDTH < 1) begin : g_bad_width
    $error("pdphp_sync2: WIDTH must be at least 1");
  end

  // Next values, frozen while the enable is low
  always_comb begin
    next_meta = ce_in ? d_in : meta;
    next_q = ce_in ? meta : q_out;
  end

  // Two stages
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      meta <= RESET_VAL;
      q_out <= RESET_VAL;
    end else begin
      meta <= next_meta;
      q_out <= next_q;
    end
  end

endmodule

`default_nettype wire

/* File: verilog/pdphp_color_ram.sv */
// Color palette memory: one write port, two registered read ports.
// Assumes writes and reads share one clock; contents are not reset.
`timescale 1ns/100ps
`default_nettype none

module pdphp_color_ram #(
  parameter int DEPTH = 256,
  parameter int AW = 8,
  parameter int DW = 24
) (
  input wire logic clk_in,
  input wire logic ce_in,
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [DW-1:0] wdata_in,
  input wire logic [AW-1:0] raddr_a_in,
  output logic [DW-1:0] rdata_a_out,
  input wire logic [AW-1:0] raddr_b_in,
  output logic [DW-1:0] rdata_b_out
);

  logic [DW-1:0] mem [DEPTH];

  // Address width must cover the depth exactly
  if (DEPTH != (1 << AW)) begin : g_bad_depth
    $error("pdphp_color_ram: DEPTH must equal 2**AW");
  end

  // Separate ports keep lookups clean during host writes
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      if (we_in) begin
        mem[waddr_in] <= wdata_in;
      end
      rdata_a_out <= mem[raddr_a_in];
      rdata_b_out <= mem[raddr_b_in];
    end
  end

endmodule

`default_nettype wire

/* File: verilog/pdphp_top.sv */
// Palette DAC digital side: pixel capture, palette lookup and host port.
// Assumes pixel inputs are on MCLK_IN; host strobes, select, data and
// level straps are asynchronous and pass two flip-flops first.
//
// How it works
// - Blank low forces colors to blanking level
// - Blank low ignores pixel and overlay inputs
// - Setup pin chooses 0 or 7.5 IRE
// - Sync low switches off 40 IRE source
// - Capture index, overlay, sync, blank together
// - Masked 8-bit index picks one of 256
// - Nonzero overlay select chooses overlay, index then ignored
// - Overlay zero passes index; 1-15 pick overlay
// - Index ANDed with host pixel mask first
// - Write strobe fall samples register select
// - Write strobe rise captures data bus
// - Read strobe low: select sampled, bus driven
// - Select code chooses pointer, palette, mask, overlay
// - Modulo-3 counter; pointer steps after blue
// - Data bus driven only during reads
// - Width high: full 8-bit color values
// - Width low: bits 5-0, upper ignored/zero
`timescale 1ns/100ps
`default_nettype none

module pdphp_top
  import pdphp_pkg::*;
(
  input wire logic MCLK_IN,
  input wire logic RST_B_IN,
  input wire logic CE_IN,
  input wire logic [7:0] PIXEL_INDEX_IN,
  input wire logic [3:0] OVERLAY_SELECT_IN,
  input wire logic SYNC_B_IN,
  input wire logic BLANK_B_IN,
  input wire logic SETUP_IN,
  input wire logic WIDTH_8BIT_IN,
  input wire logic RD_B_IN,
  input wire logic WR_B_IN,
  input wire logic [2:0] REGISTER_SELECT_IN,
  input wire logic [7:0] HOST_DATA_IN,
  output logic [7:0] HOST_DATA_OUT,
  output logic HOST_DATA_OE_OUT,
  output logic [7:0] RED_OUT,
  output logic [7:0] GREEN_OUT,
  output logic [7:0] BLUE_OUT,
  output logic PEDESTAL_ON_OUT,
  output logic SYNC_SOURCE_ON_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised host pins and straps

  logic [14:0] async_s;
  logic rd_s;
  logic wr_s;
  logic setup_s;
  logic wid8_s;
  logic [2:0] sel_s;
  logic [7:0] data_s;

  // Strobes idle high after reset
  pdphp_sync2 #(.WIDTH(15), .RESET_VAL(15'h6000)) u_sync (
    .clk_in(MCLK_IN),
    .rst_b_in(RST_B_IN),
    .ce_in(CE_IN),
    .d_in({RD_B_IN, WR_B_IN, SETUP_IN, WIDTH_8BIT_IN, REGISTER_SELECT_IN, HOST_DATA_IN}),
    .q_out(async_s)
  );

  assign {rd_s, wr_s, setup_s, wid8_s, sel_s, data_s} = async_s;

  ////////////////////////////////////////////////////////////////////////////
  // Host port state

  logic rd_q;
  logic wr_q;
  logic wr_fall;
  logic wr_rise;
  logic rd_fall;
  logic rd_rise;
  logic [7:0] ptr;
  logic [1:0] cyc;
  pdphp_mode_e mode;
  logic [2:0] host_sel;
  logic [7:0] red_w;
  logic [7:0] green_w;
  pdphp_color_s hold;
  logic [7:0] pix_mask;
  logic [1:0] fetch;
  pdphp_color_s ovl [OVL_ENTRIES];
  logic [7:0] next_ptr;
  logic [1:0] next_cyc;
  pdphp_mode_e next_mode;
  logic [2:0] next_host_sel;
  logic [7:0] next_red_w;
  logic [7:0] next_green_w;
  pdphp_color_s next_hold;
  logic [7:0] next_pix_mask;
  logic [1:0] next_fetch;
  pdphp_color_s next_ovl [OVL_ENTRIES];
  logic [7:0] next_dout;
  logic next_oe;
  logic ram_we;
  pdphp_color_s ram_wdata;
  pdphp_color_s ram_host_q;
  logic [7:0] cval;
  logic [2:0] sel_eff;
  logic [7:0] comp;

  // Strobe edges from the synchronised levels
  assign wr_fall = wr_q && !wr_s;
  assign wr_rise = !wr_q && wr_s;
  assign rd_fall = rd_q && !rd_s;
  assign rd_rise = !rd_q && rd_s;

  // Incoming color value in the chosen width
  assign cval = wid8_s ? data_s : {data_s[5:0], 2'h0};

  // Host next-state logic
  always_comb begin
    next_ptr = ptr;
    next_cyc = cyc;
    next_mode = mode;
    next_host_sel = host_sel;
    next_red_w = red_w;
    next_green_w = green_w;
    next_hold = hold;
    next_pix_mask = pix_mask;
    next_fetch = {fetch[0], 1'b0};
    next_ovl = ovl;
    ram_we = 1'b0;
    ram_wdata = {red_w, green_w, cval};
    // Copy addressed entry into the read holding registers
    if (fetch[1]) begin
      next_hold = (mode == PDPHP_OVL_RD) ? ovl[ptr[3:0]] : ram_host_q;
      next_ptr = ptr + 8'h01;
    end
    if (wr_fall || rd_fall) begin
      next_host_sel = sel_s;
    end
    if (wr_rise) begin
      case (host_sel)
        SEL_PAL_PTR_WR, SEL_PAL_PTR_RD, SEL_OVL_PTR_WR, SEL_OVL_PTR_RD: begin
          next_ptr = data_s;
          next_cyc = CYC_RED;
          case (host_sel)
            SEL_PAL_PTR_WR: next_mode = PDPHP_PAL_WR;
            SEL_PAL_PTR_RD: next_mode = PDPHP_PAL_RD;
            SEL_OVL_PTR_WR: next_mode = PDPHP_OVL_WR;
            default: next_mode = PDPHP_OVL_RD;
          endcase
          if (host_sel == SEL_PAL_PTR_RD || host_sel == SEL_OVL_PTR_RD) begin
            next_fetch = FETCH_START;
          end
        end
        SEL_PIX_MASK: begin
          next_pix_mask = data_s;
        end
        SEL_PALETTE, SEL_OVERLAY: begin
          case (cyc)
            CYC_RED: begin
              next_red_w = cval;
              next_cyc = CYC_GREEN;
            end
            CYC_GREEN: begin
              next_green_w = cval;
              next_cyc = CYC_BLUE;
            end
            default: begin
              next_cyc = CYC_RED;
              next_ptr = ptr + 8'h01;
              if (host_sel == SEL_PALETTE) begin
                ram_we = 1'b1;
              end else if (ptr[3:0] != OVL_PASS) begin
                next_ovl[ptr[3:0]] = {red_w, green_w, cval};
              end
            end
          endcase
        end
        default: begin
          next_ptr = ptr; // Reserved code ignored
        end
      endcase
    end
    // Read side effects at end of strobe; pointer reads change nothing
    if (rd_rise && (host_sel == SEL_PALETTE || host_sel == SEL_OVERLAY)) begin
      if (cyc == CYC_BLUE) begin
        next_cyc = CYC_RED;
        next_fetch = FETCH_START;
      end else begin
        next_cyc = cyc + 2'h1;
      end
    end
    // Read data, using the select taken at this very strobe fall
    sel_eff = rd_fall ? sel_s : host_sel;
    case (cyc)
      CYC_RED: comp = hold.red;
      CYC_GREEN: comp = hold.green;
      default: comp = hold.blue;
    endcase
    case (sel_eff)
      SEL_PAL_PTR_WR, SEL_PAL_PTR_RD, SEL_OVL_PTR_WR, SEL_OVL_PTR_RD: next_dout = ptr;
      SEL_PIX_MASK: next_dout = pix_mask;
      SEL_PALETTE, SEL_OVERLAY: next_dout = wid8_s ? comp : {2'h0, comp[7:2]};
      default: next_dout = DATA_RST;
    endcase
    next_oe = !rd_s;
  end

  // Host registers
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      rd_q <= 1'b1;
      wr_q <= 1'b1;
      ptr <= PTR_RST;
      cyc <= CYC_RED;
      mode <= PDPHP_PAL_WR;
      host_sel <= SEL_PAL_PTR_WR;
      red_w <= DATA_RST;
      green_w <= DATA_RST;
      hold <= '0;
      pix_mask <= PIX_MASK_RST;
      fetch <= 2'h0;
      HOST_DATA_OUT <= DATA_RST;
      HOST_DATA_OE_OUT <= 1'b0;
      for (int i = 0; i < OVL_ENTRIES; i++) begin
        ovl[i] <= '0;
      end
    end else if (CE_IN) begin
      rd_q <= rd_s;
      wr_q <= wr_s;
      ptr <= next_ptr;
      cyc <= next_cyc;
      mode <= next_mode;
      host_sel <= next_host_sel;
      red_w <= next_red_w;
      green_w <= next_green_w;
      hold <= next_hold;
      pix_mask <= next_pix_mask;
      fetch <= next_fetch;
      HOST_DATA_OUT <= next_dout;
      HOST_DATA_OE_OUT <= next_oe;
      ovl <= next_ovl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel pipeline

  pdphp_pixel_s sa;
  pdphp_pixel_s sb;
  pdphp_color_s ovl_q;
  pdphp_color_s pal_q;
  pdphp_pixel_s next_sa;
  pdphp_pixel_s next_sb;
  pdphp_color_s next_ovl_q;
  pdphp_color_s next_color;
  logic next_pedestal;
  logic next_sync_on;
  logic [7:0] pix_addr;

  // Palette: host writes on one port, pixel and host reads on others
  pdphp_color_ram #(.DEPTH(PALETTE_DEPTH), .AW(8), .DW(24)) u_ram (
    .clk_in(MCLK_IN),
    .ce_in(CE_IN),
    .we_in(ram_we),
    .waddr_in(ptr),
    .wdata_in(ram_wdata),
    .raddr_a_in(pix_addr),
    .rdata_a_out(pal_q),
    .raddr_b_in(ptr),
    .rdata_b_out(ram_host_q)
  );

  assign pix_addr = sa.index & pix_mask;

  // Pipeline next values
  always_comb begin
    next_sa = {PIXEL_INDEX_IN, OVERLAY_SELECT_IN, SYNC_B_IN, BLANK_B_IN};
    next_sb = sa;
    next_ovl_q = (sa.overlay == OVL_PASS) ? '0 : ovl[sa.overlay];
    if (!sb.blank_n) begin
      next_color = '0;
    end else if (sb.overlay != OVL_PASS) begin
      next_color = ovl_q;
    end else begin
      next_color = pal_q;
    end
    next_pedestal = sb.blank_n && setup_s;
    next_sync_on = sb.sync_n;
  end

  // Pipeline registers
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      sa <= '0;
      sb <= '0;
      ovl_q <= '0;
      {RED_OUT, GREEN_OUT, BLUE_OUT} <= '0;
      PEDESTAL_ON_OUT <= 1'b0;
      SYNC_SOURCE_ON_OUT <= 1'b0;
    end else if (CE_IN) begin
      sa <= next_sa;
      sb <= next_sb;
      ovl_q <= next_ovl_q;
      {RED_OUT, GREEN_OUT, BLUE_OUT} <= next_color;
      PEDESTAL_ON_OUT <= next_pedestal;
      SYNC_SOURCE_ON_OUT <= next_sync_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!RST_B_IN);

  a_blank_black: assert property ((CE_IN && !sa.blank_n) ##1 CE_IN |=>
      ({RED_OUT, GREEN_OUT, BLUE_OUT} == 24'h000000 && !PEDESTAL_ON_OUT))
    else $error("blanked pixel not at blanking level");
  a_blank_ignores_ovl: assert property ((CE_IN && !sa.blank_n && sa.overlay != 4'h0) ##1 CE_IN |=>
      (RED_OUT == 8'h00 && GREEN_OUT == 8'h00))
    else $error("overlay visible while blanked");
  a_pedestal_setup: assert property ((CE_IN && sa.blank_n && setup_s) ##1 (CE_IN && setup_s) |=>
      PEDESTAL_ON_OUT)
    else $error("pedestal missing with setup high");
  a_sync_source: assert property ((CE_IN && !sa.sync_n) ##1 CE_IN |=> !SYNC_SOURCE_ON_OUT)
    else $error("sync source on while sync low");
  a_capture_group: assert property (CE_IN |=> sa == $past(next_sa) && sb == $past(sa))
    else $error("pixel inputs not captured together");
  a_palette_path: assert property ((CE_IN && sb.blank_n && sb.overlay == 4'h0) |=>
      {RED_OUT, GREEN_OUT, BLUE_OUT} == $past(pal_q))
    else $error("palette color not shown");
  a_overlay_path: assert property ((CE_IN && sb.blank_n && sb.overlay != 4'h0) |=>
      {RED_OUT, GREEN_OUT, BLUE_OUT} == $past(ovl_q))
    else $error("overlay color not shown");
  a_wr_select: assert property ((CE_IN && wr_fall) |=> host_sel == $past(sel_s))
    else $error("select not taken at write fall");
  a_mask_write: assert property ((CE_IN && wr_rise && host_sel == SEL_PIX_MASK) |=>
      pix_mask == $past(data_s))
    else $error("mask not captured at write rise");
  a_bus_idle: assert property ((CE_IN && rd_s) |=> !HOST_DATA_OE_OUT)
    else $error("bus driven outside a read");
  a_six_bit_read: assert property ((CE_IN && !rd_s && !rd_fall && !wid8_s &&
      (host_sel == SEL_PALETTE || host_sel == SEL_OVERLAY)) |=> HOST_DATA_OUT[7:6] == 2'h0)
    else $error("upper bits set on 6-bit read");
  a_blue_step: assert property ((CE_IN && wr_rise && host_sel == SEL_PALETTE && cyc == CYC_BLUE) |=>
      ptr == $past(ptr) + 8'h01 && cyc == CYC_RED)
    else $error("pointer not stepped after blue");

  c_palette_write: cover property (CE_IN && ram_we);
  c_overlay_shown: cover property (CE_IN && sb.blank_n && sb.overlay != 4'h0);
  c_color_read: cover property (CE_IN && fetch[1] && mode == PDPHP_PAL_RD);
  c_blank_sync: cover property (CE_IN && !sb.blank_n && !sb.sync_n);

endmodule

`default_nettype wire

/* File: sim/pdphp_host_model.sv */
// Host processor and frame buffer model facing the palette DAC ports.
// Assumes one clock; the bench calls its tasks, pins move after edges.
`timescale 1ns/100ps
`default_nettype none

module pdphp_host_model
  import pdphp_pkg::*;
(
  input wire logic clk_in,
  input wire logic oe_in,
  input wire logic [7:0] rdata_in,
  output logic rd_b_out,
  output logic wr_b_out,
  output logic [2:0] sel_out,
  output logic [7:0] data_out,
  output pdphp_pixel_s pix_out
);
  logic [7:0] drv;
  logic drv_on;

  ////////////////////////////////////////
  // Bus level: device, host, else inverse of last host value
  always_comb begin
    data_out = oe_in ? rdata_in : (drv_on ? drv : ~drv);
  end

  // Idle pins at time zero, screen blanked until the palette is loaded
  initial begin
    rd_b_out = 1'b1;
    wr_b_out = 1'b1;
    sel_out = 3'h0;
    drv = 8'h00;
    drv_on = 1'b0;
    pix_out = '{index: 8'h00, overlay: 4'h0, sync_n: 1'b1, blank_n: 1'b0};
  end

  ////////////////////////////////////////
  // Write cycle, read strobe stays idle
  task automatic wr(input logic [2:0] sel, input logic [7:0] d);
    @(posedge clk_in);
    wr_b_out <= 1'b0;
    sel_out <= sel;
    drv <= d;
    drv_on <= 1'b1;
    repeat (5) @(posedge clk_in);
    wr_b_out <= 1'b1;
    repeat (5) @(posedge clk_in);
    drv_on <= 1'b0;
  endtask

  // Read cycle, strobe held until output enable is seen or 12 cycles pass
  task automatic rd(input logic [2:0] sel, output logic [7:0] d, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    @(posedge clk_in);
    rd_b_out <= 1'b0;
    sel_out <= sel;
    while (!ok && n < 12) begin
      @(posedge clk_in);
      ok = (oe_in === 1'b1);
      n++;
    end
    d = rdata_in;
    rd_b_out <= 1'b1;
    repeat (5) @(posedge clk_in);
  endtask

  // Pixel source, sync low only inside blanking
  task automatic pix(input pdphp_pixel_s p);
    @(posedge clk_in);
    pix_out <= '{index: p.index, overlay: p.overlay, sync_n: p.sync_n | p.blank_n, blank_n: p.blank_n};
  endtask
endmodule

`default_nettype wire

/* File: sim/pdphp_bench.sv */
// Self-checking bench of the palette DAC pixel and host port.
// Assumes the host model drives strobes, select, data and pixels; the bench drives reset, clock enable, setup and width.
`timescale 1ns/100ps
`default_nettype none

module pdphp_bench
  import pdphp_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic setup = 1'b0;
  logic width8 = 1'b1;
  logic ce = 1'b1;
  logic rd_b, wr_b, oe, ped, sync_on, ok;
  logic [2:0] sel;
  logic [7:0] hd_in, hd_out, red, green, blue, rdv;
  pdphp_pixel_s pix;
  int failures = 0;
  int comparisons = 0;

  always #4 clk = ~clk;

  pdphp_top DUT (.MCLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(ce),
    .PIXEL_INDEX_IN(pix.index), .OVERLAY_SELECT_IN(pix.overlay),
    .SYNC_B_IN(pix.sync_n), .BLANK_B_IN(pix.blank_n), .SETUP_IN(setup),
    .WIDTH_8BIT_IN(width8), .RD_B_IN(rd_b), .WR_B_IN(wr_b),
    .REGISTER_SELECT_IN(sel), .HOST_DATA_IN(hd_in), .HOST_DATA_OUT(hd_out),
    .HOST_DATA_OE_OUT(oe), .RED_OUT(red), .GREEN_OUT(green), .BLUE_OUT(blue),
    .PEDESTAL_ON_OUT(ped), .SYNC_SOURCE_ON_OUT(sync_on));

  pdphp_host_model host (.clk_in(clk), .oe_in(oe), .rdata_in(hd_out), .rd_b_out(rd_b),
    .wr_b_out(wr_b), .sel_out(sel), .data_out(hd_in), .pix_out(pix));

  ////////////////////////////////////////
  // Compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Pointer write, then red, green, blue
  task automatic set_entry(input logic [2:0] ps, input logic [2:0] ds, input logic [7:0] p,
      input logic [7:0] r, input logic [7:0] g, input logic [7:0] b);
    host.wr(ps, p);
    host.wr(ds, r);
    host.wr(ds, g);
    host.wr(ds, b);
  endtask

  // One pixel held, colors checked once the pipe has settled
  task automatic show(input logic [7:0] i, input logic [3:0] o, input logic s, input logic b,
      input logic [7:0] er, input logic [7:0] eg, input logic [7:0] eb);
    host.pix('{index: i, overlay: o, sync_n: s, blank_n: b});
    repeat (5) @(posedge clk);
    #1;
    check("red", red, er);
    check("green", green, eg);
    check("blue", blue, eb);
  endtask

  // Host read with bounded wait
  task automatic rd(input logic [2:0] s, input logic [7:0] exp, input string what);
    host.rd(s, rdv, ok);
    if (!ok) begin
      failures++;
      $display("ERROR %s expected enable seen none", what);
      stop_test();
    end else begin
      check(what, rdv, exp);
    end
  endtask

  ////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check("enable", {7'h00, oe}, 8'h00);
    check("red", red, 8'h00);
    $display("Test reset done");
    set_entry(SEL_PAL_PTR_WR, SEL_PALETTE, 8'h05, 8'hC5, 8'h3A, 8'h81);
    show(8'h05, OVL_PASS, 1'b1, 1'b1, 8'hC5, 8'h3A, 8'h81);
    check("pedestal", {7'h00, ped}, 8'h00);
    check("sync", {7'h00, sync_on}, 8'h01);
    host.wr(SEL_PAL_PTR_WR, 8'h06);
    host.wr(SEL_PALETTE, 8'h11);
    host.wr(SEL_PALETTE, 8'h22);
    set_entry(SEL_PAL_PTR_WR, SEL_PALETTE, 8'h06, 8'h31, 8'h32, 8'h33);
    show(8'h06, OVL_PASS, 1'b1, 1'b1, 8'h31, 8'h32, 8'h33);
    $display("Test palette write done");
    host.wr(SEL_PIX_MASK, 8'h0F);
    show(8'hF5, OVL_PASS, 1'b1, 1'b1, 8'hC5, 8'h3A, 8'h81);
    show(8'h06, OVL_PASS, 1'b1, 1'b1, 8'h31, 8'h32, 8'h33);
    host.wr(SEL_PIX_MASK, 8'hFF);
    set_entry(SEL_OVL_PTR_WR, SEL_OVERLAY, 8'h01, 8'h44, 8'h55, 8'h66);
    show(8'h06, 4'h1, 1'b1, 1'b1, 8'h44, 8'h55, 8'h66);
    $display("Test mask and overlay done");
    @(posedge clk);
    setup <= 1'b1;
    show(8'h05, OVL_PASS, 1'b1, 1'b1, 8'hC5, 8'h3A, 8'h81);
    check("pedestal", {7'h00, ped}, 8'h01);
    show(8'h05, 4'h1, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
    check("pedestal", {7'h00, ped}, 8'h00);
    check("sync", {7'h00, sync_on}, 8'h00);
    show(8'h06, OVL_PASS, 1'b1, 1'b0, 8'h00, 8'h00, 8'h00);
    check("sync", {7'h00, sync_on}, 8'h01);
    $display("Test blank and sync done");
    @(posedge clk);
    ce <= 1'b0;
    show(8'h05, OVL_PASS, 1'b1, 1'b1, 8'h00, 8'h00, 8'h00);
    @(posedge clk);
    ce <= 1'b1;
    $display("Test clock enable done");
    host.wr(SEL_PAL_PTR_RD, 8'h05);
    rd(SEL_PALETTE, 8'hC5, "red read");
    rd(SEL_PALETTE, 8'h3A, "green read");
    rd(SEL_PALETTE, 8'h81, "blue read");
    check("enable", {7'h00, oe}, 8'h00);
    rd(SEL_PAL_PTR_WR, 8'h07, "pointer");
    rd(SEL_RESERVED, 8'h00, "reserved");
    rd(SEL_PALETTE, 8'h31, "next red");
    host.wr(SEL_OVL_PTR_RD, 8'h01);
    rd(SEL_OVERLAY, 8'h44, "overlay read");
    $display("Test read back done");
    width8 <= 1'b0;
    rd(SEL_OVERLAY, 8'h15, "narrow read");
    set_entry(SEL_PAL_PTR_WR, SEL_PALETTE, 8'h07, 8'hFF, 8'hC1, 8'h00);
    show(8'h07, OVL_PASS, 1'b1, 1'b1, 8'hFC, 8'h04, 8'h00);
    $display("Test narrow width done");
    stop_test();
  end
endmodule

`default_nettype wire
